// File: tpc_cfg.svh
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// Compare datapath width and reset values
`define TPC_CMP_W           8
`define TPC_CMP_RST         8'h00
`define TPC_MODE_RST        8'h00

// Field positions inside the mode control word
`define TPC_MODE_EN_POS     7
`define TPC_MODE_CKS_POS    4
`define TPC_MODE_MD_POS     2
`define TPC_MODE_LEV_POS    1
`define TPC_MODE_OE_POS     0

// Count clocks a latched duty value must age before it may be taken
`define TPC_DUTY_SETTLE     2'h3
// Count clocks from the synchronised frame edge to the gate transfer
`define TPC_GATE_XFER_DLY   2'h2

// Prescaler: divide ratio as a power of two per clock select code
`define TPC_PRE_W           12
`define TPC_PRE_LOG0        4'h0
`define TPC_PRE_LOG1        4'h2
`define TPC_PRE_LOG2        4'h4
`define TPC_PRE_LOG3        4'h6
`define TPC_PRE_LOG4        4'hC
`define TPC_PRE_LOG5        4'h7
`define TPC_PRE_LOG6        4'h9
`define TPC_PRE_LOG7        4'h0

`endif

// File: tpc_pkg.sv
package tpc_pkg;

	// Operating modes of the compare timer
	typedef enum logic [1:0] {
		TPC_MODE_INTERVAL,
		TPC_MODE_CARRIER,
		TPC_MODE_PWM,
		TPC_MODE_RESERVED
	} tpc_mode_e;

	// Run sequence of the counter
	typedef enum logic [1:0] {
		TPC_RUN_IDLE,
		TPC_RUN_MASK,
		TPC_RUN_PERIOD,
		TPC_RUN_DUTY
	} tpc_run_e;

	// Mode control word, bit 7 down to bit 0
	typedef struct packed {
		logic      count_enable_bit;
		logic [2:0] clk_sel;
		tpc_mode_e mode;
		logic      default_level_bit;
		logic      output_enable_bit;
	} tpc_mode_t;

endpackage

// File: tpc_prescale.sv
`timescale 1ns/10ps
`include "tpc_cfg.svh"

module tpc_prescale
	import tpc_pkg::*;
#(
	parameter logic [3:0] LOG5 = `TPC_PRE_LOG5,
	parameter logic [3:0] LOG6 = `TPC_PRE_LOG6,
	parameter logic [3:0] LOG7 = `TPC_PRE_LOG7
)
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [2:0] clk_sel,
	output logic            tick
);

	logic [`TPC_PRE_W-1:0] div_cnt;
	logic [`TPC_PRE_W-1:0] next_div_cnt;
	logic [`TPC_PRE_W-1:0] sel_mask;

	// Divide exponent for a clock select code
	function automatic logic [3:0] sel_log(input logic [2:0] sel);
		case (sel)
			3'h0:    sel_log = `TPC_PRE_LOG0;
			3'h1:    sel_log = `TPC_PRE_LOG1;
			3'h2:    sel_log = `TPC_PRE_LOG2;
			3'h3:    sel_log = `TPC_PRE_LOG3;
			3'h4:    sel_log = `TPC_PRE_LOG4;
			3'h5:    sel_log = LOG5;
			3'h6:    sel_log = LOG6;
			default: sel_log = LOG7;
		endcase
	endfunction

	// Free running divider; a select change mid-run may shorten one period
	always_comb
	begin
		next_div_cnt = div_cnt + 12'h001;
		sel_mask     = 12'(({1'b0, 12'hFFF} >> (4'hC - sel_log(clk_sel))));
		tick         = ((div_cnt & sel_mask) == sel_mask);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			div_cnt <= 12'h000;
		else
			div_cnt <= next_div_cnt;
	end

endmodule // tpc_prescale

// File: tpc_duty_latch.sv
`timescale 1ns/10ps
`include "tpc_cfg.svh"

module tpc_duty_latch
	import tpc_pkg::*;
#(
	parameter int W = `TPC_CMP_W
)
(
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         tick,
	input  wire logic         running,
	input  wire logic         duty_wr,
	input  wire logic [W-1:0] duty_wdata,
	input  wire logic         duty_hit,
	output logic [W-1:0]      duty_cmp,
	output logic              duty_pending
);

	logic [W-1:0] latch_val;
	logic [1:0]   age;
	logic [W-1:0] next_latch_val;
	logic [W-1:0] next_duty_cmp;
	logic         next_duty_pending;
	logic [1:0]   next_age;
	logic         take;

	// Write latch, settle counter and transfer on the old duty match
	always_comb
	begin
		next_latch_val    = latch_val;
		next_duty_cmp     = duty_cmp;
		next_duty_pending = duty_pending;
		next_age          = age;
		take              = duty_hit && duty_pending && !duty_wr
		                    && (age >= `TPC_DUTY_SETTLE);
		if (duty_wr && running)
		begin
			next_latch_val    = duty_wdata;
			next_duty_pending = 1'b1;
			next_age          = 2'h0;
		end
		else if (duty_wr)
		begin
			// Stopped: no compare in flight, load straight through
			next_latch_val    = duty_wdata;
			next_duty_cmp     = duty_wdata;
			next_duty_pending = 1'b0;
		end
		else
		begin
			if (tick && (age < `TPC_DUTY_SETTLE))
				next_age = age + 2'h1;
			if (take)
			begin
				next_duty_cmp     = latch_val;
				next_duty_pending = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			latch_val    <= `TPC_CMP_RST;
			duty_cmp     <= `TPC_CMP_RST;
			duty_pending <= 1'b0;
			age          <= 2'h0;
		end
		else
		begin
			latch_val    <= next_latch_val;
			duty_cmp     <= next_duty_cmp;
			duty_pending <= next_duty_pending;
			age          <= next_age;
		end
	end

endmodule // tpc_duty_latch

// File: tpc_carrier_out.sv
// Functional notes
// - Counting starts once the count enable bit is set.
// - First count clock after enable is masked; outside carrier mode, output holds default until first match.
// - First compare is period; match clears, interrupts, inverts, switches to duty outside interval mode.
// - PWM duty match inverts and switches back; no clear, no interrupt.
// - PWM period is period value plus one count clocks.
// - PWM duty is duty value plus one over period value plus one.
// - Duty writes while running are latched, taken at the old duty match.
// - Duty match within three count clocks after a write keeps the old value.
// - Clearing count enable returns interrupt and, outside carrier mode, output to default.
// - Carrier mode: period sets low width, duty sets high width.
// - Carrier is sent in the frame cycle of the companion frame timer.
// - Remote enable and active gate select low, high or carrier output.
// - Gate is a writable buffer bit and a read-only active bit.
// - Frame interrupt synchronised to count clock strobes buffer into active gate.
// - Active gate loads at second count clock after the synchronised edge.
// - Default level bit sets stopped level outside carrier mode; output enable bit gates pin.
`timescale 1ns/10ps
`include "tpc_cfg.svh"

module tpc_carrier_out
	import tpc_pkg::*;
#(
	parameter int         W    = `TPC_CMP_W,
	parameter logic [3:0] LOG5 = `TPC_PRE_LOG5,
	parameter logic [3:0] LOG6 = `TPC_PRE_LOG6,
	parameter logic [3:0] LOG7 = `TPC_PRE_LOG7
)
(
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire tpc_mode_t    mode_ctl_reg,
	input  wire logic         remote_ctl_enable,
	input  wire logic [W-1:0] period_cmp,
	input  wire logic         duty_wr,
	input  wire logic [W-1:0] duty_wdata,
	input  wire logic         gate_buffer_wr,
	input  wire logic         gate_buffer_wdata,
	input  wire logic         frame_timer_irq,
	output logic              pulse_out,
	output logic              match_irq,
	output logic              gate_buffer_bit,
	output logic              gate_active_bit,
	output logic              frame_irq_synced,
	output logic [W-1:0]      duty_cmp,
	output logic              duty_pending,
	output logic [W-1:0]      count_value,
	output logic              count_tick
);

	////////////////////////////////////////////////////////////////////////////
	// Count clock and duty latch

	logic     tick;
	logic     running;
	logic     duty_hit;
	tpc_run_e run_state;

	// Counter step; wraps by design, legal settings never reach the top
	function automatic logic [W-1:0] count_next(input logic [W-1:0] cur);
		count_next = W'(cur + 1'b1);
	endfunction

	// Compare match, only on a count clock so a stalled count cannot retrigger
	function automatic logic cmp_hit(input logic en, input logic [W-1:0] cur,
		input logic [W-1:0] target);
		cmp_hit = en && (cur == target);
	endfunction

	tpc_prescale #(
		.LOG5    (LOG5),
		.LOG6    (LOG6),
		.LOG7    (LOG7)
	) u_prescale (
		.clk     (clk),
		.reset_n (reset_n),
		.clk_sel (mode_ctl_reg.clk_sel),
		.tick    (tick)
	);

	tpc_duty_latch #(
		.W            (W)
	) u_duty_latch (
		.clk          (clk),
		.reset_n      (reset_n),
		.tick         (tick),
		.running      (running),
		.duty_wr      (duty_wr),
		.duty_wdata   (duty_wdata),
		.duty_hit     (duty_hit),
		.duty_cmp     (duty_cmp),
		.duty_pending (duty_pending)
	);

	// Running means a compare may be in flight, so duty writes must wait
	assign running    = (run_state != TPC_RUN_IDLE);
	// Interval mode never looks at the duty value
	assign duty_hit   = cmp_hit(tick, count_value, duty_cmp) && (run_state == TPC_RUN_DUTY)
	                    && (mode_ctl_reg.mode != TPC_MODE_INTERVAL);
	assign count_tick = tick;

	////////////////////////////////////////////////////////////////////////////
	// Counter and compare sequencing

	tpc_run_e     next_run_state;
	logic [W-1:0] next_count_value;
	logic         wave;
	logic         next_wave;
	logic         next_match_irq;
	logic         mode_ok;

	// Reserved mode code keeps the counter parked like a stop
	assign mode_ok = (mode_ctl_reg.mode != TPC_MODE_RESERVED);

	always_comb
	begin
		next_run_state   = run_state;
		next_count_value = count_value;
		next_wave        = wave;
		next_match_irq   = 1'b0;
		if (!mode_ctl_reg.count_enable_bit || !mode_ok)
		begin
			// Stop clears counter, interrupt and inversion state
			next_run_state   = TPC_RUN_IDLE;
			next_count_value = `TPC_CMP_RST;
			next_wave        = 1'b0;
		end
		else
		begin
			case (run_state)
				TPC_RUN_IDLE:
				begin
					next_run_state = TPC_RUN_MASK;
				end
				TPC_RUN_MASK:
				begin
					// The first count clock is swallowed, no increment
					if (tick)
						next_run_state = TPC_RUN_PERIOD;
				end
				TPC_RUN_PERIOD:
				begin
					if (cmp_hit(tick, count_value, period_cmp))
					begin
						next_count_value = `TPC_CMP_RST;
						next_match_irq   = 1'b1;
						next_wave        = !wave;
						// Interval mode keeps comparing against the period only
						if (mode_ctl_reg.mode != TPC_MODE_INTERVAL)
							next_run_state = TPC_RUN_DUTY;
					end
					else if (tick)
						next_count_value = count_next(count_value);
				end
				TPC_RUN_DUTY:
				begin
					if (duty_hit)
					begin
						next_wave      = !wave;
						next_run_state = TPC_RUN_PERIOD;
						if (mode_ctl_reg.mode == TPC_MODE_CARRIER)
						begin
							// Carrier: each half restarts from zero
							next_count_value = `TPC_CMP_RST;
							next_match_irq   = 1'b1;
						end
						else
							next_count_value = count_next(count_value);
					end
					else if (tick)
						next_count_value = count_next(count_value);
				end
				default:
				begin
					next_run_state = TPC_RUN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_state   <= TPC_RUN_IDLE;
			count_value <= `TPC_CMP_RST;
			wave        <= 1'b0;
			match_irq   <= 1'b0;
		end
		else
		begin
			run_state   <= next_run_state;
			count_value <= next_count_value;
			wave        <= next_wave;
			match_irq   <= next_match_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame interrupt synchronisation and gate transfer

	logic       frame_pend;
	logic       next_frame_pend;
	logic       next_frame_irq_synced;
	logic [1:0] xfer_cnt;
	logic [1:0] next_xfer_cnt;
	logic       next_gate_buffer_bit;
	logic       next_gate_active_bit;

	// Frame pulse is held until the next count clock picks it up
	always_comb
	begin
		next_frame_pend       = frame_pend;
		next_frame_irq_synced = frame_irq_synced;
		next_xfer_cnt         = xfer_cnt;
		next_gate_buffer_bit  = gate_buffer_bit;
		next_gate_active_bit  = gate_active_bit;
		if (gate_buffer_wr)
			next_gate_buffer_bit = gate_buffer_wdata;
		if (tick)
		begin
			next_frame_irq_synced = frame_pend;
			next_frame_pend       = 1'b0;
			if (frame_pend && !frame_irq_synced)
				next_xfer_cnt = `TPC_GATE_XFER_DLY;
			else if (xfer_cnt != 2'h0)
				next_xfer_cnt = xfer_cnt - 2'h1;
			if (xfer_cnt == 2'h1)
				next_gate_active_bit = gate_buffer_bit;
		end
		// A new frame event beats the clear on the same cycle
		if (frame_timer_irq)
			next_frame_pend = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_pend       <= 1'b0;
			frame_irq_synced <= 1'b0;
			xfer_cnt         <= 2'h0;
			gate_buffer_bit  <= 1'b0;
			gate_active_bit  <= 1'b0;
		end
		else
		begin
			frame_pend       <= next_frame_pend;
			frame_irq_synced <= next_frame_irq_synced;
			xfer_cnt         <= next_xfer_cnt;
			gate_buffer_bit  <= next_gate_buffer_bit;
			gate_active_bit  <= next_gate_active_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output level selection

	logic level;
	logic next_pulse_out;

	// Registered pin drive avoids glitches when mode bits move together
	always_comb
	begin
		level = mode_ctl_reg.default_level_bit;
		case (mode_ctl_reg.mode)
			TPC_MODE_INTERVAL,
			TPC_MODE_PWM:
			begin
				level = mode_ctl_reg.default_level_bit ^ wave;
			end
			TPC_MODE_CARRIER:
			begin
				if (remote_ctl_enable)
					level = gate_active_bit & wave;
				else
					level = gate_active_bit;
			end
			default:
			begin
				level = mode_ctl_reg.default_level_bit;
			end
		endcase
		next_pulse_out = mode_ctl_reg.output_enable_bit & level;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pulse_out <= 1'b0;
		else
			pulse_out <= next_pulse_out;
	end

endmodule // tpc_carrier_out

// File: tpc_frame_model.sv
`timescale 1ns/10ps

module tpc_frame_model #(
	parameter int FRAME_LEN = 200
)
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic run,
	output logic      frame_timer_irq
);
	int cnt;

	// Frame counter; slow next to the count clock so sync is safe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cnt <= 0;
		else
			cnt <= (run && cnt < FRAME_LEN - 1) ? cnt + 1 : 0;
	end

	// One-clk frame pulse sets the carrier frame cycle
	assign frame_timer_irq = run && cnt == FRAME_LEN - 1;
endmodule // tpc_frame_model

// File: tpc_co_checker.sv
`timescale 1ns/10ps

module tpc_co_checker
	import tpc_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic         clk,
	input wire logic         reset_n,
	input wire tpc_mode_t    mode_ctl_reg,
	input wire logic         remote_ctl_enable,
	input wire logic [W-1:0] period_cmp,
	input wire logic         gate_buffer_wr,
	input wire logic         gate_buffer_wdata,
	input wire logic         frame_timer_irq,
	input wire logic         pulse_out,
	input wire logic         match_irq,
	input wire logic         gate_buffer_bit,
	input wire logic         gate_active_bit,
	input wire logic         frame_irq_synced,
	input wire logic [W-1:0] count_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Decoded control fields
	wire logic en   = mode_ctl_reg.count_enable_bit;
	wire logic lev  = mode_ctl_reg.default_level_bit;
	wire logic oe   = mode_ctl_reg.output_enable_bit;
	wire logic pwm  = mode_ctl_reg.mode == TPC_MODE_PWM;
	wire logic car  = mode_ctl_reg.mode == TPC_MODE_CARRIER;
	wire logic fast = mode_ctl_reg.clk_sel == 3'h0;

	////////////////////////////////////////////////////////////////
	// Steps of start-up and of the gate transfer
	sequence s_masked_start;
		count_value == '0 ##1 count_value == '0;
	endsequence

	sequence s_sync_recent;
		$past(frame_irq_synced) || $past(frame_irq_synced, 2) || $past(frame_irq_synced, 3);
	endsequence

	a_mask_first: assert property ($rose(en) && pwm && fast |-> ##1 s_masked_start)
		else $error("count moved on the masked clock");
	a_irq_period: assert property (match_irq && pwm |->
		$past(count_value) == period_cmp || $past(count_value, 2) == period_cmp)
		else $error("interrupt not at period match");
	a_count_bound: assert property (en && pwm |-> count_value <= period_cmp)
		else $error("count ran past period");
	a_stop_default: assert property ((!en && pwm && $stable(mode_ctl_reg))[*3] |->
		pulse_out == (lev & oe) && !match_irq)
		else $error("stopped output not at default");
	a_oe_off: assert property ((!oe)[*2] |-> !pulse_out)
		else $error("pin driven with output off");
	a_gate_write: assert property (gate_buffer_wr |=> gate_buffer_bit == $past(gate_buffer_wdata))
		else $error("gate buffer write lost");
	a_gate_xfer: assert property ($changed(gate_active_bit) && fast |->
		gate_active_bit == $past(gate_buffer_bit) ##0 s_sync_recent)
		else $error("gate moved without frame strobe");
	a_sync_follow: assert property (frame_timer_irq && fast |-> ##[1:3] frame_irq_synced)
		else $error("frame pulse not synchronised");
	a_carrier_plain: assert property ((car && !remote_ctl_enable && oe)[*2] |->
		pulse_out == $past(gate_active_bit))
		else $error("plain level differs from gate");
	a_carrier_gated: assert property ((car && !gate_active_bit)[*2] |-> !pulse_out)
		else $error("carrier out with gate closed");
endmodule // tpc_co_checker

// File: testbench.sv
`timescale 1ns/10ps

module testbench
	import tpc_pkg::*;
;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	tpc_mode_t  mode_ctl_reg = '0;
	logic       remote_ctl_enable = 1'b0;
	logic [7:0] period_cmp = 8'h00;
	logic       duty_wr = 1'b0;
	logic [7:0] duty_wdata = 8'h00;
	logic       gate_buffer_wr = 1'b0;
	logic       gate_buffer_wdata = 1'b0;
	logic       frame_run = 1'b0;
	logic       frame_timer_irq, pulse_out, match_irq, gate_buffer_bit, gate_active_bit;
	logic       frame_irq_synced, duty_pending, count_tick, lv, s0, s1;
	logic [7:0] duty_cmp, count_value;
	int         err_total = 0, checks = 0, seed = 32'h72D2AE24;
	int         hi, lo, n, m, cs, k;
	int         cn[3] = '{255, 255, 1};
	int         cm[3] = '{0, 254, 0};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	tpc_frame_model #(.FRAME_LEN(200)) frame_u (.clk(clk), .reset_n(reset_n), .run(frame_run),
		.frame_timer_irq(frame_timer_irq));
	tpc_carrier_out dut_u (.clk(clk), .reset_n(reset_n), .mode_ctl_reg(mode_ctl_reg),
		.remote_ctl_enable(remote_ctl_enable), .period_cmp(period_cmp), .duty_wr(duty_wr),
		.duty_wdata(duty_wdata), .gate_buffer_wr(gate_buffer_wr),
		.gate_buffer_wdata(gate_buffer_wdata), .frame_timer_irq(frame_timer_irq),
		.pulse_out(pulse_out), .match_irq(match_irq), .gate_buffer_bit(gate_buffer_bit),
		.gate_active_bit(gate_active_bit), .frame_irq_synced(frame_irq_synced),
		.duty_cmp(duty_cmp), .duty_pending(duty_pending), .count_value(count_value),
		.count_tick(count_tick));

	////////////////////////////////////////////////////////////////
	// Compare, report, finish
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %0s finished", s);
	endtask

	// Active width of one PWM cycle, in clk cycles
	function automatic int pwm_hi(input int nn, input int mm, input logic l, input int d);
		return (l ? nn - mm : mm + 1) * d;
	endfunction

	// Mode word change; other bits only move while stopped
	task automatic setm(input logic en, input tpc_mode_e md, input int c, input logic l,
		input logic oe);
		@(posedge clk);
		mode_ctl_reg <= '{en, c[2:0], md, l, oe};
	endtask

	task automatic wduty(input int v);
		@(posedge clk);
		duty_wr    <= 1'b1;
		duty_wdata <= v[7:0];
		@(posedge clk);
		duty_wr <= 1'b0;
	endtask

	// Cycles until the pin reaches a level, bounded
	task automatic upto(input logic v, output int c);
		c = 0;
		while (pulse_out !== v && c < 5000)
		begin
			@(negedge clk);
			c++;
		end
	endtask

	// Skip to a whole cycle, then time its high and low parts
	task automatic measure();
		int c;
		upto(1'b0, c);
		upto(1'b1, c);
		upto(1'b0, hi);
		upto(1'b1, lo);
	endtask

	// Period only written while stopped
	task automatic run_pwm(input int nn, input int mm, input int c, input logic l);
		setm(1'b0, TPC_MODE_PWM, c, l, 1'b1);
		period_cmp <= nn[7:0];
		wduty(mm);
		setm(1'b1, TPC_MODE_PWM, c, l, 1'b1);
		measure();
	endtask

	task automatic stop(input logic l);
		@(posedge clk);
		mode_ctl_reg.count_enable_bit <= 1'b0;
		repeat (3) @(negedge clk);
		check(pulse_out, l);
		check(match_irq, 0);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		// Corner pairs, then random ones inside the legal range
		for (int i = 0; i < 9; i++)
		begin
			n  = i < 3 ? cn[i] : 1 + {$random(seed)} % 40;
			m  = i < 3 ? cm[i] : {$random(seed)} % n;
			cs = i < 3 ? 0 : $random(seed) & 1;
			lv = $random(seed) & 1;
			run_pwm(n, m, cs, lv);
			check(hi, pwm_hi(n, m, lv, 1 << 2 * cs));
			check(hi + lo, (n + 1) << 2 * cs);
			stop(lv);
		end
		done("pwm");
		// A settled write is taken at the old match, an early one waits
		run_pwm(40, 10, 0, 1'b0);
		wduty(20);
		@(negedge clk);
		check(duty_pending, 1);
		check(duty_cmp, 10);
		measure();
		check(hi, 21);
		check(duty_cmp, 20);
		check(duty_pending, 0);
		stop(1'b0);
		run_pwm(40, 1, 1, 1'b0);
		wduty(30);
		@(negedge clk);
		check(duty_cmp, 1);
		measure();
		check(hi, 8);
		measure();
		check(hi, 124);
		check(duty_cmp, 30);
		stop(1'b0);
		done("duty latch");
		// Count clock rate for select codes 0 to 3, whole divider spans
		for (int c = 0; c < 4; c++)
		begin
			setm(1'b0, TPC_MODE_INTERVAL, c, 1'b0, 1'b1);
			repeat (2) @(negedge clk);
			k = 0;
			repeat (128)
			begin
				@(negedge clk);
				k += count_tick;
			end
			check(k, 128 >> 2 * c);
		end
		done("clock select");
		setm(1'b0, TPC_MODE_INTERVAL, 0, 1'b0, 1'b1);
		period_cmp <= 8'h09;
		setm(1'b1, TPC_MODE_INTERVAL, 0, 1'b0, 1'b1);
		measure();
		check(hi, 10);
		check(lo, 10);
		stop(1'b0);
		setm(1'b0, TPC_MODE_RESERVED, 0, 1'b1, 1'b1);
		setm(1'b1, TPC_MODE_RESERVED, 0, 1'b1, 1'b1);
		repeat (20) @(negedge clk);
		check(count_value, 0);
		check(pulse_out, 1);
		setm(1'b0, TPC_MODE_RESERVED, 0, 1'b1, 1'b1);
		setm(1'b0, TPC_MODE_RESERVED, 0, 1'b1, 1'b0);
		repeat (3) @(negedge clk);
		check(pulse_out, 0);
		done("modes");
		// Carrier: every remote and gate pairing, gate moved by frame pulses
		setm(1'b0, TPC_MODE_CARRIER, 0, 1'b0, 1'b1);
		period_cmp <= 8'h05;
		frame_run  <= 1'b1;
		wduty(3);
		setm(1'b1, TPC_MODE_CARRIER, 0, 1'b0, 1'b1);
		check(duty_cmp, 3);
		check(duty_pending, 0);
		for (int g = 0; g < 4; g++)
		begin
			// One gate write per loop pass, far apart
			@(posedge clk);
			remote_ctl_enable <= g[1];
			gate_buffer_wr    <= 1'b1;
			gate_buffer_wdata <= g[0];
			@(posedge clk);
			gate_buffer_wr <= 1'b0;
			k = 0;
			while (gate_active_bit !== g[0] && k < 400)
			begin
				@(negedge clk);
				k++;
			end
			check(gate_active_bit, g[0]);
			s0 = 1'b0;
			s1 = 1'b0;
			repeat (8) @(negedge clk);
			repeat (40)
			begin
				@(negedge clk);
				s0 |= !pulse_out;
				s1 |= pulse_out;
			end
			check({s1, s0}, {g[0], !(g[0] && !g[1])});
		end
		measure();
		check(hi, 4);
		check(lo, 6);
		// Reset in mid-run clears gate and pin
		@(posedge clk);
		frame_run <= 1'b0;
		reset_n   <= 1'b0;
		repeat (5) @(negedge clk);
		check({gate_active_bit, pulse_out}, 0);
		@(posedge clk);
		reset_n <= 1'b1;
		done("carrier");
		conclude();
	end

	// Watchdog at 250 us, well beyond the expected run length
	initial
	begin
		#250000;
		err_total++;
		conclude();
	end
endmodule // testbench

bind tpc_carrier_out tpc_co_checker #(.W(W)) chk_u (.clk(clk), .reset_n(reset_n),
	.mode_ctl_reg(mode_ctl_reg), .remote_ctl_enable(remote_ctl_enable),
	.period_cmp(period_cmp), .gate_buffer_wr(gate_buffer_wr),
	.gate_buffer_wdata(gate_buffer_wdata), .frame_timer_irq(frame_timer_irq),
	.pulse_out(pulse_out), .match_irq(match_irq), .gate_buffer_bit(gate_buffer_bit),
	.gate_active_bit(gate_active_bit), .frame_irq_synced(frame_irq_synced),
	.count_value(count_value));
